//--- src/cbo_pkg.sv
// constants and types shared by the barrier ordering router
package cbo_pkg;
   localparam int unsigned NPORT_DEF = 2;
   localparam int unsigned ADDR_W_DEF = 32;
   localparam int unsigned NOBS_DEF = 4;
   localparam int unsigned OUT_W_DEF = 8;
   localparam int unsigned BAR_MAX = 256;
   localparam int unsigned BAR_CNT_W = 9;
   localparam logic [BAR_CNT_W-1:0] BAR_CNT_RST = 9'h000;

   // barrier pair sequencing, gray along idle -> wait -> emit; emit -> idle changes both bits
   typedef enum logic [1:0]
   {
      CBO_IDLE = 2'h0,
      CBO_WAIT = 2'h1,
      CBO_EMIT = 2'h3
   } cbo_state_t;
endpackage : cbo_pkg

//--- src/cbo_bar_cnt.sv
// per-port count of accepted write-channel barriers awaiting their read partner
`timescale 1ns/10ps
module cbo_bar_cnt
#(
   parameter int unsigned CNT_W = cbo_pkg::BAR_CNT_W,
   parameter int unsigned MAX = cbo_pkg::BAR_MAX
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inc,
   input wire logic dec,
   output logic full,
   output logic nonzero
);
   localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX);
   localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   // count up on acceptance, down when the pair leaves
   always_comb
   begin
      cnt_d = cnt_q;
      if (inc && !dec)
      begin
         cnt_d = cnt_q + ONE_C;
      end
      else if (dec && !inc)
      begin
         cnt_d = cnt_q - ONE_C;
      end
   end

   // flags are registered so the top sees stable levels
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= cbo_pkg::BAR_CNT_RST;
         full <= 1'b0;
         nonzero <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         full <= (cnt_d == MAX_C);
         nonzero <= (cnt_d != cbo_pkg::BAR_CNT_RST);
      end
   end
endmodule : cbo_bar_cnt

//--- src/cbo_top.sv
// barrier ordering merge of several upstream ports onto one downstream port, plus snoop observation
`timescale 1ns/10ps
module cbo_top
#(
   parameter int unsigned NPORT = cbo_pkg::NPORT_DEF,
   parameter int unsigned ADDR_W = cbo_pkg::ADDR_W_DEF,
   parameter int unsigned NOBS = cbo_pkg::NOBS_DEF,
   parameter int unsigned OUT_W = cbo_pkg::OUT_W_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NPORT-1:0] ar_valid,
   input wire logic [NPORT-1:0] ar_bar,
   input wire logic [NPORT-1:0][ADDR_W-1:0] ar_addr,
   output logic [NPORT-1:0] ar_ready,
   input wire logic [NPORT-1:0] aw_valid,
   input wire logic [NPORT-1:0] aw_bar,
   input wire logic [NPORT-1:0][ADDR_W-1:0] aw_addr,
   output logic [NPORT-1:0] aw_ready,
   output logic out_ar_valid,
   output logic out_ar_bar,
   output logic [ADDR_W-1:0] out_ar_addr,
   input wire logic out_ar_ready,
   output logic out_aw_valid,
   output logic out_aw_bar,
   output logic [ADDR_W-1:0] out_aw_addr,
   input wire logic out_aw_ready,
   input wire logic rd_resp,
   input wire logic wr_resp,
   input wire logic snp_req,
   input wire logic [NOBS-1:0] obs_ack,
   output logic snp_busy,
   output logic snp_resp_valid,
   input wire logic snp_resp_ready,
   output logic obs_done
);
   localparam logic [OUT_W-1:0] OUT_ZERO = '0;
   localparam logic [OUT_W-1:0] OUT_ONE = OUT_W'(1);
   localparam int unsigned PW = (NPORT > 1) ? $clog2(NPORT) : 1;
   localparam logic [PW-1:0] P_LAST = PW'(NPORT - 1);
   localparam logic [PW-1:0] P_ONE = PW'(1);
   localparam logic [PW-1:0] P_ZERO = '0;

   cbo_pkg::cbo_state_t state_q;
   cbo_pkg::cbo_state_t state_d;
   logic [PW-1:0] lock_q;
   logic [PW-1:0] lock_d;
   logic [PW-1:0] rr_q;
   logic [PW-1:0] rr_d;
   logic [NPORT-1:0] ar_rdy_d;
   logic [NPORT-1:0] aw_rdy_d;
   logic [NPORT-1:0] bar_full;
   logic [NPORT-1:0] bar_nz;
   logic [NPORT-1:0] bar_inc;
   logic [NPORT-1:0] ar_hs;
   logic [NPORT-1:0] aw_hs;
   logic ar_take;
   logic aw_take;
   logic emit_take;
   logic [OUT_W-1:0] rd_out_q;
   logic [OUT_W-1:0] rd_out_d;
   logic [OUT_W-1:0] wr_out_q;
   logic [OUT_W-1:0] wr_out_d;
   logic oar_v_d;
   logic oar_b_d;
   logic [ADDR_W-1:0] oar_a_d;
   logic oaw_v_d;
   logic oaw_b_d;
   logic [ADDR_W-1:0] oaw_a_d;
   logic [NOBS-1:0] seen_q;
   logic [NOBS-1:0] seen_d;
   logic busy_d;
   logic resp_v_d;
   logic obs_d;
   logic drained;

   // upstream handshakes; ready is pulsed for a standing valid, except the wait-state read barrier release, which ignores ar_valid
   assign ar_hs = ar_valid & ar_ready;
   assign aw_hs = aw_valid & aw_ready;
   assign ar_take = |ar_hs;
   assign aw_take = |(aw_hs & ~aw_bar);
   assign emit_take = (state_q == cbo_pkg::CBO_EMIT) && ar_hs[lock_q];
   assign bar_inc = aw_hs & aw_bar;
   // pre-barrier traffic all answered and nothing parked downstream
   assign drained = (rd_out_q == OUT_ZERO) && (wr_out_q == OUT_ZERO) && !out_ar_valid && !out_aw_valid;

   // one write-barrier counter per port, all able to accept at once
   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++)
      begin : g_port
         cbo_bar_cnt #(.CNT_W(cbo_pkg::BAR_CNT_W), .MAX(cbo_pkg::BAR_MAX)) u_cnt
         (
            .clk(clk),
            .rst_n(rst_n),
            .inc(bar_inc[gp]),
            .dec(emit_take && (lock_q == PW'(gp))),
            .full(bar_full[gp]),
            .nonzero(bar_nz[gp])
         );
         // a write barrier is taken within two cycles while the counter has room
         AST_AW_BAR_ACCEPT: assert property (@(posedge clk) disable iff (!rst_n)
            (aw_valid[gp] && aw_bar[gp] && !bar_full[gp] && !aw_ready[gp]) |-> ##[1:2] aw_ready[gp])
            else $error("write barrier not accepted although room remained");
      end
   endgenerate

   // arbitration, barrier pair sequencing and ready pulses
   always_comb
   begin
      int unsigned k;
      logic [PW-1:0] p;
      logic found;
      k = 0;
      p = P_ZERO;
      found = 1'b0;
      state_d = state_q;
      lock_d = lock_q;
      rr_d = rr_q;
      ar_rdy_d = '0;
      aw_rdy_d = '0;
      // barrier writes bypass the slot so the write channel never stalls on them
      for (k = 0; k < NPORT; k++)
      begin
         aw_rdy_d[k] = aw_valid[k] && aw_bar[k] && !bar_full[k] && !aw_ready[k];
      end
      case (state_q)
         cbo_pkg::CBO_IDLE:
         begin
            // single downstream path for every address: fixed routing
            for (k = 0; k < NPORT; k++)
            begin
               p = (rr_q + PW'(k) > P_LAST) ? rr_q + PW'(k) - PW'(NPORT) : rr_q + PW'(k);
               if (!found && ar_valid[p])
               begin
                  found = 1'b1;
                  if (ar_bar[p])
                  begin
                     state_d = cbo_pkg::CBO_WAIT;
                     lock_d = p;
                  end
                  else if (!out_ar_valid && !ar_take && (ar_ready == '0))
                  begin
                     ar_rdy_d[p] = 1'b1;
                     rr_d = (p == P_LAST) ? P_ZERO : p + P_ONE;
                  end
               end
            end
            found = 1'b0;
            // ordinary writes, one per slot
            for (k = 0; k < NPORT; k++)
            begin
               if (!found && aw_valid[k] && !aw_bar[k] && !out_aw_valid && !aw_take && !(|(aw_ready & ~aw_bar)))
               begin
                  found = 1'b1;
                  aw_rdy_d[k] = 1'b1;
               end
            end
         end
         cbo_pkg::CBO_WAIT:
         begin
            // release the read barrier: partner arrived and every earlier access answered,
            // which spans any peripheral range, known or not
            if (bar_nz[lock_q] && drained && !aw_take && !(|(aw_ready & ~aw_bar)))
            begin
               ar_rdy_d[lock_q] = 1'b1;
               state_d = cbo_pkg::CBO_EMIT;
            end
         end
         cbo_pkg::CBO_EMIT:
         begin
            state_d = cbo_pkg::CBO_IDLE;
            rr_d = (lock_q == P_LAST) ? P_ZERO : lock_q + P_ONE;
         end
         default:
         begin
            state_d = cbo_pkg::CBO_IDLE;
         end
      endcase
   end

   // downstream slots; a barrier loads both channels together as one pair
   always_comb
   begin
      int unsigned j;
      j = 0;
      oar_v_d = out_ar_valid && !out_ar_ready;
      oar_b_d = out_ar_bar;
      oar_a_d = out_ar_addr;
      oaw_v_d = out_aw_valid && !out_aw_ready;
      oaw_b_d = out_aw_bar;
      oaw_a_d = out_aw_addr;
      for (j = 0; j < NPORT; j++)
      begin
         if (ar_hs[j])
         begin
            oar_v_d = 1'b1;
            oar_b_d = ar_bar[j];
            oar_a_d = ar_addr[j];
         end
         if (aw_hs[j] && !aw_bar[j])
         begin
            oaw_v_d = 1'b1;
            oaw_b_d = 1'b0;
            oaw_a_d = aw_addr[j];
         end
      end
      if (emit_take)
      begin
         oaw_v_d = 1'b1;
         oaw_b_d = 1'b1;
         oaw_a_d = ar_addr[lock_q];
      end
   end

   // outstanding downstream accesses; issue and answer in one cycle cancel
   always_comb
   begin
      rd_out_d = rd_out_q;
      wr_out_d = wr_out_q;
      if ((out_ar_valid && out_ar_ready) && !rd_resp)
      begin
         rd_out_d = rd_out_q + OUT_ONE;
      end
      else if (!(out_ar_valid && out_ar_ready) && rd_resp && (rd_out_q != OUT_ZERO))
      begin
         rd_out_d = rd_out_q - OUT_ONE;
      end
      if ((out_aw_valid && out_aw_ready) && !wr_resp)
      begin
         wr_out_d = wr_out_q + OUT_ONE;
      end
      else if (!(out_aw_valid && out_aw_ready) && wr_resp && (wr_out_q != OUT_ZERO))
      begin
         wr_out_d = wr_out_q - OUT_ONE;
      end
   end

   // snoop observation: response only once every observer acknowledged
   always_comb
   begin
      busy_d = snp_busy;
      seen_d = seen_q;
      resp_v_d = snp_resp_valid;
      obs_d = 1'b0;
      if (!snp_busy && snp_req)
      begin
         busy_d = 1'b1;
         seen_d = obs_ack; // an ack in the request cycle is kept
      end
      else if (snp_busy)
      begin
         seen_d = seen_q | obs_ack;
         if (&seen_q && !snp_resp_valid)
         begin
            resp_v_d = 1'b1;
         end
         if (snp_resp_valid && snp_resp_ready)
         begin
            resp_v_d = 1'b0;
            busy_d = 1'b0;
            obs_d = 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= cbo_pkg::CBO_IDLE;
         lock_q <= '0;
         rr_q <= '0;
         ar_ready <= '0;
         aw_ready <= '0;
         out_ar_valid <= 1'b0;
         out_ar_bar <= 1'b0;
         out_ar_addr <= '0;
         out_aw_valid <= 1'b0;
         out_aw_bar <= 1'b0;
         out_aw_addr <= '0;
         rd_out_q <= '0;
         wr_out_q <= '0;
         snp_busy <= 1'b0;
         seen_q <= '0;
         snp_resp_valid <= 1'b0;
         obs_done <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         lock_q <= lock_d;
         rr_q <= rr_d;
         ar_ready <= ar_rdy_d;
         aw_ready <= aw_rdy_d;
         out_ar_valid <= oar_v_d;
         out_ar_bar <= oar_b_d;
         out_ar_addr <= oar_a_d;
         out_aw_valid <= oaw_v_d;
         out_aw_bar <= oaw_b_d;
         out_aw_addr <= oaw_a_d;
         rd_out_q <= rd_out_d;
         wr_out_q <= wr_out_d;
         snp_busy <= busy_d;
         seen_q <= seen_d;
         snp_resp_valid <= resp_v_d;
         obs_done <= obs_d;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_emit_grant;
      (state_q == cbo_pkg::CBO_WAIT) ##1 (state_q == cbo_pkg::CBO_EMIT);
   endsequence
   sequence s_pair_out;
      out_ar_valid && out_ar_bar && out_aw_valid && out_aw_bar;
   endsequence

   AST_RBAR_NEEDS_WBAR: assert property ((state_q == cbo_pkg::CBO_EMIT) |-> bar_nz[lock_q])
      else $error("read barrier released without its write partner");
   AST_RBAR_DRAINED: assert property (s_emit_grant |-> drained)
      else $error("read barrier released before earlier traffic drained");
   AST_PAIR_TOGETHER: assert property (s_emit_grant ##1 1'b1 |-> s_pair_out)
      else $error("barrier pair not emitted on both channels together");
   AST_NO_OVERTAKE: assert property ($rose(out_ar_valid && out_ar_bar) |-> $past(drained, 2))
      else $error("barrier overtook an earlier transaction");
   AST_EMIT_ONE: assert property ((state_q == cbo_pkg::CBO_EMIT) |=> (state_q == cbo_pkg::CBO_IDLE))
      else $error("emit state held longer than one cycle");
   AST_ONE_PATH: assert property ($onehot0(ar_ready))
      else $error("more than one read port granted at once");
   AST_SNP_ALL_SEEN: assert property (snp_resp_valid |-> (&seen_q))
      else $error("snoop response before all observers saw the write");
   AST_SNP_HOLD: assert property ((snp_resp_valid && !snp_resp_ready) |=> snp_resp_valid)
      else $error("snoop response dropped before its handshake");
   AST_OBS_AT_HS: assert property ((snp_resp_valid && snp_resp_ready) |=> obs_done ##1 !obs_done)
      else $error("observation not marked at the snoop response handshake");
endmodule : cbo_top

//--- sim/cbo_slv_model.sv
// downstream slave model answering the merged read and write address channels
`timescale 1ns/10ps
module cbo_slv_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic out_ar_valid,
   input wire logic out_aw_valid,
   output logic out_ar_ready,
   output logic out_aw_ready,
   output logic rd_resp,
   output logic wr_resp
);
   logic [1:0] ar_wait_q;
   logic [1:0] aw_wait_q;
   logic [9:0] rd_pend_q;
   logic [9:0] wr_pend_q;

   // accept at once, or stall two cycles when slow
   assign out_ar_ready = out_ar_valid && (!slow || ar_wait_q == 2'h2);
   assign out_aw_ready = out_aw_valid && (!slow || aw_wait_q == 2'h2);

   // stall counters and one response pulse per accepted request
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ar_wait_q <= 2'h0;
         aw_wait_q <= 2'h0;
         rd_pend_q <= 10'h000;
         wr_pend_q <= 10'h000;
         rd_resp <= 1'b0;
         wr_resp <= 1'b0;
      end
      else
      begin
         ar_wait_q <= (out_ar_valid && !out_ar_ready) ? ar_wait_q + 2'h1 : 2'h0;
         aw_wait_q <= (out_aw_valid && !out_aw_ready) ? aw_wait_q + 2'h1 : 2'h0;
         rd_pend_q <= rd_pend_q + 10'(out_ar_valid && out_ar_ready) - 10'(rd_resp);
         wr_pend_q <= wr_pend_q + 10'(out_aw_valid && out_aw_ready) - 10'(wr_resp);
         rd_resp <= (rd_pend_q != 10'h000) && !rd_resp; // responses trail, so drain is observable
         wr_resp <= (wr_pend_q != 10'h000) && !wr_resp;
      end
   end
endmodule : cbo_slv_model

//--- sim/coherent_barrier_ordering_tb.sv
// self-checking bench for the barrier ordering router
`timescale 1ns/10ps
module coherent_barrier_ordering_tb;
   localparam int NP = 2;
   localparam int AW = 32;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   logic [NP-1:0] ar_valid = '0, ar_bar = '0, aw_valid = '0, aw_bar = '0;
   logic [NP-1:0][AW-1:0] ar_addr = '0, aw_addr = '0;
   logic [NP-1:0] ar_ready, aw_ready;
   logic out_ar_valid, out_ar_bar, out_ar_ready, out_aw_valid, out_aw_bar, out_aw_ready;
   logic [AW-1:0] out_ar_addr, out_aw_addr, ar_addr_seen, aw_addr_seen;
   logic rd_resp, wr_resp, snp_busy, snp_resp_valid, obs_done, ar_bar_seen, aw_bar_seen;
   logic snp_req = 1'b0;
   logic snp_resp_ready = 1'b0;
   logic [3:0] obs_ack = 4'h0;
   int bad_count = 0;
   int n_tests = 0;
   int ar_hs = 0, aw_hs = 0, rsp_n = 0, gap = -1, pair_bad = 0;
   bit ok;

   always #12.5 clk = ~clk;

   cbo_top #(.NPORT(NP), .ADDR_W(AW), .NOBS(4), .OUT_W(8)) i_dut (.clk(clk), .rst_n(rst_n),
      .ar_valid(ar_valid), .ar_bar(ar_bar), .ar_addr(ar_addr), .ar_ready(ar_ready),
      .aw_valid(aw_valid), .aw_bar(aw_bar), .aw_addr(aw_addr), .aw_ready(aw_ready),
      .out_ar_valid(out_ar_valid), .out_ar_bar(out_ar_bar), .out_ar_addr(out_ar_addr),
      .out_ar_ready(out_ar_ready), .out_aw_valid(out_aw_valid), .out_aw_bar(out_aw_bar),
      .out_aw_addr(out_aw_addr), .out_aw_ready(out_aw_ready), .rd_resp(rd_resp), .wr_resp(wr_resp),
      .snp_req(snp_req), .obs_ack(obs_ack), .snp_busy(snp_busy), .snp_resp_valid(snp_resp_valid),
      .snp_resp_ready(snp_resp_ready), .obs_done(obs_done));

   cbo_slv_model i_slv (.clk(clk), .rst_n(rst_n), .slow(slow), .out_ar_valid(out_ar_valid),
      .out_aw_valid(out_aw_valid), .out_ar_ready(out_ar_ready), .out_aw_ready(out_aw_ready),
      .rd_resp(rd_resp), .wr_resp(wr_resp));

   // downstream handshake log, outstanding count at barrier issue, split pair count
   always @(posedge clk)
   begin
      if (out_ar_valid && out_ar_ready)
      begin
         ar_hs <= ar_hs + 1;
         ar_bar_seen <= out_ar_bar;
         ar_addr_seen <= out_ar_addr;
         if (out_ar_bar)
            gap <= ar_hs + aw_hs - rsp_n;
      end
      if (out_aw_valid && out_aw_ready)
      begin
         aw_hs <= aw_hs + 1;
         aw_bar_seen <= out_aw_bar;
         aw_addr_seen <= out_aw_addr;
      end
      if ((out_ar_valid && out_ar_bar) != (out_aw_valid && out_aw_bar))
         pair_bad <= pair_bad + 1;
      rsp_n <= rsp_n + int'(rd_resp) + int'(wr_resp);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one upstream request held until its ready is sampled, or until lim edges pass
   task automatic req(input bit w, input int p, input logic b, input logic [31:0] a, input int lim,
      output bit got);
      got = 1'b0;
      @(posedge clk);
      if (w)
      begin
         aw_valid[p] <= 1'b1;
         aw_bar[p] <= b;
         aw_addr[p] <= a;
      end
      else
      begin
         ar_valid[p] <= 1'b1;
         ar_bar[p] <= b;
         ar_addr[p] <= a;
      end
      for (int i = 0; i < lim && !got; i++)
      begin
         @(posedge clk);
         got = w ? (aw_ready[p] === 1'b1) : (ar_ready[p] === 1'b1);
      end
      if (w)
         aw_valid[p] <= 1'b0;
      else
         ar_valid[p] <= 1'b0;
   endtask : req

   task automatic wait_hs(input int ea, input int eb);
      for (int i = 0; i < 60 && (ar_hs != ea || aw_hs != eb); i++)
         @(posedge clk);
      chk("downstream handshakes", 32'(ea * 256 + eb), 32'(ar_hs * 256 + aw_hs));
   endtask : wait_hs

   // ordinary reads and writes from both ports pass straight through
   task automatic t_plain();
      for (int s = 0; s < 2; s++)
      begin
         slow <= s[0];
         req(1'b0, s, 1'b0, 32'h1000_0010 + s, 20, ok);
         chk("read taken", 1, ok);
         req(1'b1, 1 - s, 1'b0, 32'h2000_0020 + s, 20, ok);
         chk("write taken", 1, ok);
         wait_hs(s + 1, s + 1);
         chk("read addr", 32'h1000_0010 + s, ar_addr_seen);
         chk("write addr", 32'h2000_0020 + s, aw_addr_seen);
         chk("plain bar", 0, {ar_bar_seen, aw_bar_seen});
      end
   endtask : t_plain

   // barrier pair behind outstanding traffic, write barrier first
   task automatic t_barrier();
      slow <= 1'b1;
      req(1'b0, 1, 1'b0, 32'h3000_0000, 20, ok);
      req(1'b1, 0, 1'b1, 32'h4000_0040, 20, ok);
      chk("write barrier taken", 1, ok);
      req(1'b0, 0, 1'b1, 32'h5000_0050, 200, ok);
      chk("read barrier taken", 1, ok);
      wait_hs(4, 3);
      chk("pair bar", 32'h3, {ar_bar_seen, aw_bar_seen});
      chk("pair addr", 32'h5000_0050, aw_addr_seen);
      chk("split pair", 0, pair_bad);
      chk("undrained", 0, gap);
   endtask : t_barrier

   // every port takes the full count of write barriers, then refuses one more
   task automatic t_capacity();
      slow <= 1'b0;
      for (int i = 0; i < 256; i++)
         for (int p = 0; p < NP; p++)
         begin
            req(1'b1, p, 1'b1, 32'h6000_0000 + i, 20, ok);
            chk("barrier accepted", 1, ok);
         end
      for (int p = 0; p < NP; p++)
      begin
         req(1'b1, p, 1'b1, 32'h6000_0100, 20, ok);
         chk("barrier over limit", 0, ok);
      end
      req(1'b1, 0, 1'b0, 32'h7000_0070, 20, ok);
      chk("write after barriers", 1, ok);
   endtask : t_capacity

   // snoop answer waits for every observer and stands until taken
   task automatic t_snoop();
      @(posedge clk);
      snp_req <= 1'b1;
      obs_ack <= 4'h1;
      @(posedge clk);
      snp_req <= 1'b0;
      obs_ack <= 4'h2;
      @(posedge clk);
      obs_ack <= 4'h4;
      @(posedge clk);
      obs_ack <= 4'h0;
      repeat (4)
      begin
         @(posedge clk);
         chk("early response", 32'h2, {snp_busy, snp_resp_valid});
      end
      obs_ack <= 4'h8;
      ok = 1'b0;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         @(posedge clk);
         obs_ack <= 4'h0;
         ok = (snp_resp_valid === 1'b1);
      end
      chk("response after all", 1, ok);
      repeat (3)
      begin
         @(posedge clk);
         chk("response stands", 1, snp_resp_valid);
      end
      snp_resp_ready <= 1'b1;
      @(posedge clk);
      snp_resp_ready <= 1'b0;
      @(posedge clk);
      chk("observed", 32'h4, {obs_done, snp_busy, snp_resp_valid});
   endtask : t_snoop

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_plain();
      t_barrier();
      t_snoop();
      t_capacity();
      end_sim();
   end

   // watchdog against a hang
   initial
   begin
      repeat (6000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule : coherent_barrier_ordering_tb
